// [iee_pkg.sv]
/*
 package for the interrupt entry/exit sequencer and its peripheral end.
 assumes a 16-bit word machine with byte addresses and a simple
 single-cycle-answer memory port on the processor side.
*/
package iee_pkg;
    localparam int WORD_W = 16;
    localparam logic [15:0] MMU_ABORT_VEC = 16'h00A8;
    localparam int DONE_BIT = 7;
    localparam int IE_BIT = 6;
    localparam int PRIO_LSB = 5;
    localparam int PRIO_W = 3;
    localparam int MODE_LSB = 14;
    localparam int REGSET_BIT = 11;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] STATUS_RST = 16'h00E0;
    localparam logic [15:0] SP_RST = 16'h1000;
    localparam logic [15:0] PC_RST = 16'h0200;
    localparam logic [7:0] VEC_TIMEOUT = 8'h10;
    localparam logic [15:0] DEV_VEC_RST = 16'h0060;
    localparam logic [2:0] DEV_PRIO_RST = 3'h4;
    localparam logic [15:0] CSR_RST = 16'h0000;
endpackage

// [iee_bus_if.sv]
/*
 interface joining the processor end to one peripheral end.
 request, grant handshake and vector read; no clocking block.
*/
`timescale 1ns/1ps
`default_nettype none
interface iee_bus_if;
    logic irq_req;
    logic [2:0] irq_prio;
    logic vec_rd;
    logic vec_ack;
    logic [15:0] vec_data;
    modport cpu (input irq_req, input irq_prio, output vec_rd,
                 input vec_ack, input vec_data);
    modport dev (output irq_req, output irq_prio, input vec_rd,
                 output vec_ack, output vec_data);
endinterface
`default_nettype wire

// [iee_dev_end.sv]
/*
 peripheral end: control/status register with done and interrupt
 enable, request logic and vector answer.
 assumes the same clock as the processor end.
*/
`timescale 1ns/1ps
`default_nettype none
module iee_dev_end
    import iee_pkg::*;
#(
    parameter logic [15:0] DEV_VEC = DEV_VEC_RST,
    parameter logic [2:0] DEV_PRIO = DEV_PRIO_RST
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // link
    iee_bus_if.dev bus,
    // user side
    input wire logic done_set_i,
    input wire logic csr_wr_i,
    input wire logic [15:0] csr_wdata_i,
    output logic [15:0] csr_o
);
    logic [15:0] csr_r;
    logic [15:0] csr_nxt;
    logic req_w;

    // hardware set of done wins over a software write in the same cycle
    always_comb begin
        csr_nxt = csr_wr_i ? csr_wdata_i : csr_r;
        if (done_set_i) begin
            csr_nxt[DONE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            csr_r <= CSR_RST;
        end else begin
            csr_r <= csr_nxt;
        end
    end

    assign req_w = csr_r[DONE_BIT] & csr_r[IE_BIT];
    assign bus.irq_req = req_w;
    assign bus.irq_prio = DEV_PRIO;
    // answer only while still requesting; a withdrawn request stays silent
    assign bus.vec_ack = bus.vec_rd & req_w;
    assign bus.vec_data = DEV_VEC;
    assign csr_o = csr_r;
endmodule
`default_nettype wire

// [iee_cpu_end.sv]
/*
 processor end: interrupt and abort entry, return sequencing.
 assumes memory answers every access in the same cycle (mem_rdata_i
 combinational from mem_addr_o) and that the core pulses its strobes.
*/
// Behaviour
// - memory management abort uses fixed vector
// - device done flag sits in bit 7
// - device requests only when done and enabled
// - finish current instruction before entry (abort entry does not wait for it)
// - suspend long commercial instructions, resume later
// - push status then pointer, predecrementing
// - load pointer then status from vector
// - new status selects mode and register set
// - return pops pointer then status
// - only pointer and status saved
// - vector read times out, resume or halt
// - next pending device answers vector read
// - software raises priority before clearing enable
// - nesting to any depth via stack
// - vectors at fixed low addresses, two words
`timescale 1ns/1ps
`default_nettype none
module iee_cpu_end
    import iee_pkg::*;
#(
    parameter bit HALT_ON_TIMEOUT = 1'b0
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // link
    iee_bus_if.cpu bus,
    // core side
    input wire logic instr_done_i,
    input wire logic long_instr_i,
    input wire logic mmu_abort_i,
    input wire logic rti_i,
    input wire logic status_wr_i,
    input wire logic [15:0] status_wdata_i,
    output logic suspended_o,
    output logic busy_o,
    output logic halted_o,
    output logic timeout_o,
    output logic [15:0] next_instruction_pointer_o,
    output logic [15:0] status_word_o,
    output logic [15:0] stack_ptr_reg_o,
    output logic [1:0] mode_o,
    output logic regset_o,
    // memory side
    output logic mem_wr_o,
    output logic mem_rd_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic [15:0] mem_rdata_i
);
    typedef enum {
        ST_RUN, ST_VREAD, ST_PUSH_ST, ST_PUSH_PC, ST_LD_PC, ST_LD_ST,
        ST_POP_PC, ST_POP_ST, ST_HALT
    } iee_state_t;

    iee_state_t state_r;
    logic [15:0] pc_r;
    logic [15:0] status_word_r;
    logic [15:0] stack_ptr_reg_r;
    logic [15:0] vec_r;
    logic [15:0] old_st_r;
    logic [7:0] tmo_r;
    logic suspended_r;
    logic timeout_r;
    logic [2:0] cur_prio_w;
    logic accept_w;
    logic boundary_w;
    logic [15:0] sp_dec_w;
    logic [15:0] sp_inc_w;
    logic [15:0] depth_r;
    logic [15:0] susp_depth_r;
    logic irq_take_w;
    logic susp_take_w;
    logic susp_end_w;
    logic tmo_end_w;

    function automatic logic [15:0] step(input logic [15:0] a,
                                         input logic up);
        step = up ? a + WORD_STEP : a - WORD_STEP;
    endfunction

    assign cur_prio_w = status_word_r[PRIO_LSB +: PRIO_W];
    assign accept_w = bus.irq_req && (bus.irq_prio > cur_prio_w);
    // a long instruction can be broken into; others wait for completion
    assign boundary_w = instr_done_i || long_instr_i;
    assign sp_dec_w = step(stack_ptr_reg_r, 1'b0);
    assign sp_inc_w = step(stack_ptr_reg_r, 1'b1);
    assign irq_take_w = (state_r == ST_RUN) && !mmu_abort_i && accept_w &&
                        boundary_w;
    assign susp_take_w = irq_take_w && long_instr_i && !instr_done_i;
    // the flag belongs to the frame that the suspending entry opens, one deeper than when it was set
    assign susp_end_w = (state_r == ST_POP_ST) &&
                        (depth_r == susp_depth_r + 16'h0001);
    assign tmo_end_w = (state_r == ST_VREAD) && !bus.vec_ack &&
                       (tmo_r == VEC_TIMEOUT);

    assign bus.vec_rd = (state_r == ST_VREAD);
    assign busy_o = (state_r != ST_RUN);
    assign halted_o = (state_r == ST_HALT);
    assign mem_wr_o = (state_r == ST_PUSH_ST) || (state_r == ST_PUSH_PC);
    assign mem_rd_o = (state_r == ST_LD_PC) || (state_r == ST_LD_ST) ||
                      (state_r == ST_POP_PC) || (state_r == ST_POP_ST);
    // predecrement: write at sp-2; only pointer and status go out
    assign mem_addr_o = mem_wr_o ? sp_dec_w :
                        (state_r == ST_LD_PC) ? vec_r :
                        (state_r == ST_LD_ST) ? step(vec_r, 1'b1) :
                        stack_ptr_reg_r;
    assign mem_wdata_o = (state_r == ST_PUSH_ST) ? old_st_r : pc_r;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_r <= ST_RUN;
            pc_r <= PC_RST;
            status_word_r <= STATUS_RST;
            stack_ptr_reg_r <= SP_RST;
            vec_r <= 16'h0000;
            old_st_r <= 16'h0000;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (status_wr_i) begin
                        status_word_r <= status_wdata_i;
                    end
                    if (mmu_abort_i) begin
                        vec_r <= MMU_ABORT_VEC;
                        old_st_r <= status_word_r;
                        state_r <= ST_PUSH_ST;
                    end else if (irq_take_w) begin
                        state_r <= ST_VREAD;
                    end else if (rti_i) begin
                        state_r <= ST_POP_PC;
                    end
                end
                ST_VREAD: begin
                    if (bus.vec_ack) begin
                        vec_r <= bus.vec_data;
                        old_st_r <= status_word_r;
                        state_r <= ST_PUSH_ST;
                    end else if (tmo_end_w) begin
                        state_r <= HALT_ON_TIMEOUT ? ST_HALT : ST_RUN;
                    end
                end
                ST_PUSH_ST: begin
                    stack_ptr_reg_r <= sp_dec_w;
                    state_r <= ST_PUSH_PC;
                end
                ST_PUSH_PC: begin
                    stack_ptr_reg_r <= sp_dec_w;
                    state_r <= ST_LD_PC;
                end
                ST_LD_PC: begin
                    pc_r <= mem_rdata_i;
                    state_r <= ST_LD_ST;
                end
                ST_LD_ST: begin
                    status_word_r <= mem_rdata_i;
                    state_r <= ST_RUN;
                end
                ST_POP_PC: begin
                    pc_r <= mem_rdata_i;
                    stack_ptr_reg_r <= sp_inc_w;
                    state_r <= ST_POP_ST;
                end
                ST_POP_ST: begin
                    status_word_r <= mem_rdata_i;
                    stack_ptr_reg_r <= sp_inc_w;
                    state_r <= ST_RUN;
                end
                ST_HALT: begin
                    state_r <= ST_HALT;
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // counts the cycles of one vector read; idle at zero elsewhere
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || state_r != ST_VREAD) begin
            tmo_r <= 8'h00;
        end else begin
            tmo_r <= tmo_r + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            timeout_r <= 1'b0;
        end else begin
            timeout_r <= tmo_end_w;
        end
    end

    // open frames; 16 bits cover every frame that a 64 KB stack holds
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            depth_r <= 16'h0000;
        end else if (state_r == ST_PUSH_PC) begin
            depth_r <= depth_r + 16'h0001;
        end else if (state_r == ST_POP_ST) begin
            depth_r <= depth_r - 16'h0001;
        end
    end

    // one flag only: a second suspension in a nested handler takes it over
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            suspended_r <= 1'b0;
            susp_depth_r <= 16'h0000;
        end else if (susp_take_w) begin
            suspended_r <= 1'b1;
            susp_depth_r <= depth_r;
        end else if (tmo_end_w || susp_end_w) begin
            suspended_r <= 1'b0;
        end
    end

    assign suspended_o = suspended_r;
    assign timeout_o = timeout_r;
    assign next_instruction_pointer_o = pc_r;
    assign status_word_o = status_word_r;
    assign stack_ptr_reg_o = stack_ptr_reg_r;
    assign mode_o = status_word_r[MODE_LSB +: 2];
    assign regset_o = status_word_r[REGSET_BIT];
endmodule
`default_nettype wire

// [iee_chk.sv]
/*
 link checker for the interrupt entry/exit pair.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module iee_chk
    import iee_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // link
    input wire logic irq_req,
    input wire logic [2:0] irq_prio,
    input wire logic vec_rd,
    input wire logic vec_ack,
    input wire logic [15:0] vec_data
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    property p_ack_cause; vec_ack |-> vec_rd && irq_req; endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("bad ack");
    property p_ack_given; vec_rd && irq_req |-> vec_ack; endproperty
    a_ack_given: assert property (p_ack_given)
        else $error("no ack");
    property p_vec_word; vec_ack |-> vec_data == DEV_VEC_RST; endproperty
    a_vec_word: assert property (p_vec_word)
        else $error("bad vec");
    property p_prio; irq_req |-> irq_prio == DEV_PRIO_RST; endproperty
    a_prio: assert property (p_prio)
        else $error("bad prio");
    property p_rd_cause; $rose(vec_rd) |-> $past(irq_req); endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("stray read");
    // a withdrawn request must not hang the read
    property p_rd_bound; vec_rd |-> ##[1:20] !vec_rd; endproperty
    a_rd_bound: assert property (p_rd_bound)
        else $error("read hangs");
    property p_ack_ends; vec_ack |=> !vec_rd; endproperty
    a_ack_ends: assert property (p_ack_ends)
        else $error("read stays");
    property p_save_gap; $fell(vec_rd) && $past(vec_ack) |-> !vec_rd [*4];
    endproperty
    a_save_gap: assert property (p_save_gap)
        else $error("short save");
    c_ack: cover property (vec_ack);
    c_withdrawn: cover property (vec_rd && !irq_req);
    c_req: cover property ($rose(irq_req));
endmodule
`default_nettype wire

// [iee_tb.sv]
/*
 bench: both ends on one link, a word memory answering in the same cycle.
 assumes package, interface, both ends and checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module iee_tb;
    import iee_pkg::*;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic done_set = '0, csr_wr = '0, ins_done = '0, long_ins = '0;
    logic abort = '0, ret = '0, st_wr = '0, saw_tmo;
    logic [15:0] csr_wd = '0, st_wd = '0, csr, nip, stw, stk, addr, wd;
    logic susp, busy, halted, tmo, regset, mwr, mrd;
    logic [1:0] mode;
    logic [15:0] mem [0:4095];
    int errors = 0, total_checks = 0, n;
    iee_bus_if bus_i ();
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (mwr) mem[addr[12:1]] <= wd;
    iee_dev_end iee_dev_end_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .bus(bus_i), .done_set_i(done_set), .csr_wr_i(csr_wr),
        .csr_wdata_i(csr_wd), .csr_o(csr));
    iee_cpu_end iee_cpu_end_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .bus(bus_i), .instr_done_i(ins_done), .long_instr_i(long_ins),
        .mmu_abort_i(abort), .rti_i(ret), .status_wr_i(st_wr),
        .status_wdata_i(st_wd), .suspended_o(susp), .busy_o(busy),
        .halted_o(halted), .timeout_o(tmo), .next_instruction_pointer_o(nip),
        .status_word_o(stw), .stack_ptr_reg_o(stk), .mode_o(mode),
        .regset_o(regset), .mem_wr_o(mwr), .mem_rd_o(mrd),
        .mem_addr_o(addr), .mem_wdata_o(wd),
        .mem_rdata_i(mrd ? mem[addr[12:1]] : 16'h0000));
    iee_chk iee_chk_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .irq_req(bus_i.irq_req), .irq_prio(bus_i.irq_prio),
        .vec_rd(bus_i.vec_rd), .vec_ack(bus_i.vec_ack),
        .vec_data(bus_i.vec_data));
    task automatic wrap_up;
        if (errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic trip(logic [15:0] a, logic [15:0] b, logic [15:0] c);
        chk("nip", a, nip);
        chk("stw", b, stw);
        chk("stk", c, stk);
    endtask
    // k: 1 boundary 2 return 3 abort 4 done 5 status 6 csr
    // 7 csr+boundary 8 csr+done
    task automatic run(int k, logic [15:0] d = '0);
        @(posedge clk_sys_i);
        ins_done <= k == 1 || k == 7;
        ret <= k == 2;
        abort <= k == 3;
        done_set <= k == 4 || k == 8;
        st_wr <= k == 5;
        csr_wr <= k > 5;
        {st_wd, csr_wd} <= {d, d};
        @(posedge clk_sys_i);
        {ins_done, ret, abort, done_set, st_wr, csr_wr} <= '0;
        #1 n = 0;
        saw_tmo = 1'b0;
        while (busy === 1'b1 && n < 40) begin
            @(posedge clk_sys_i);
            #1 n++;
            saw_tmo |= tmo;
        end
    endtask
    initial begin
        mem[DEV_VEC_RST[12:1]] = 16'h0400;
        mem[DEV_VEC_RST[12:1] + 12'h1] = 16'hC8E0;
        mem[MMU_ABORT_VEC[12:1]] = 16'h0500;
        mem[MMU_ABORT_VEC[12:1] + 12'h1] = 16'h40E0;
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1 trip(PC_RST, STATUS_RST, SP_RST);
        chk("csr", CSR_RST, csr);
        run(5, 16'h0080);
        run(6, 16'h0040);
        run(4);
        chk("csr", 16'h00C0, csr);
        run(1);
        trip(PC_RST, 16'h0080, SP_RST);
        run(5, 16'h0060);
        run(1);
        trip(16'h0400, 16'hC8E0, 16'h0FFC);
        chk("push", 16'h0060, mem[12'h7FF]);
        chk("push", PC_RST, mem[12'h7FE]);
        chk("mode", 16'h0007, {13'h0, mode, regset});
        run(3);
        trip(16'h0500, 16'h40E0, 16'h0FF8);
        chk("push", 16'h0400, mem[12'h7FC]);
        run(2);
        trip(16'h0400, 16'hC8E0, 16'h0FFC);
        run(2);
        trip(PC_RST, 16'h0060, SP_RST);
        @(posedge clk_sys_i) long_ins <= 1'b1;
        @(posedge clk_sys_i) long_ins <= 1'b0;
        run(0);
        chk("susp", 16'h0001, {15'h0, susp});
        run(3);
        run(2);
        chk("susp", 16'h0001, {15'h0, susp});
        run(2);
        chk("susp", 16'h0000, {15'h0, susp});
        // enable dropped without raising priority first
        run(7, 16'h0000);
        chk("tmo", 16'h0001, {15'h0, saw_tmo});
        chk("halt", 16'h0000, {14'h0, halted, busy});
        trip(PC_RST, 16'h0060, SP_RST);
        run(8, 16'h0040);
        chk("csr", 16'h00C0, csr);
        // enable dropped the safe way: priority up first, then down
        run(5, 16'h0080);
        run(6, 16'h0000);
        run(5, 16'h0000);
        run(1);
        chk("tmo", 16'h0000, {15'h0, saw_tmo});
        trip(PC_RST, 16'h0000, SP_RST);
        wrap_up;
    end
    initial begin
        repeat (2000) @(posedge clk_sys_i);
        errors++;
        wrap_up;
    end
endmodule
`default_nettype wire
